/* rtl/mpi_port.sv */
// Purpose: second MII port, nibble framing between user bytes and the PHY
// Assumes: clk_i well above four times the PHY clocks
// Notes: receive bytes are pushed out without back-pressure
//
// Behaviour
// - link indicator output low while the port is linked up, high otherwise
// - activity indicator low while transmitting or receiving, high otherwise
// - receive nibble captured on each rising receive clock edge
// - receive valid marks data nibbles and is sampled on receive clock
// - receive error while valid marks the frame data as errored
// - receive error with nibble E and no valid means false carrier
// - transmit nibble launched on each rising transmit clock edge
// - transmit enable rises with first preamble nibble, holds to last nibble
// - transmit error driven on transmit clock, only while enable is high
`timescale 1ns/1ps
module mpi_port
   import mpi_pkg::*;
#(
   parameter int DEPTH = mpi_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic link_up_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_last_i,
   input wire logic tx_err_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_last_o,
   output logic rx_err_o,
   output logic rx_valid_o,
   output logic false_carrier_o,
   output logic collision_o,
   output logic carrier_o,
   input wire logic port1_receive_clock_i,
   input wire logic [3:0] port1_receive_nibble_i,
   input wire logic port1_receive_valid_i,
   input wire logic port1_receive_error_i,
   input wire logic port1_collision_in_i,
   input wire logic port1_carrier_sense_i,
   input wire logic port1_transmit_clock_i,
   output logic [3:0] port1_transmit_nibble_o,
   output logic port1_transmit_enable_o,
   output logic port1_transmit_error_o,
   output logic port1_link_indicator_n_o,
   output logic port1_activity_indicator_n_o
);

   import mpi_pkg::*;

   // ------------------------------------------------
   // state of the three clock domains
   // ------------------------------------------------
   typedef struct packed {
      logic link_n;
      logic act_n;
      logic col;
      logic crs;
      logic tog_seen;
      logic fc_seen;
      logic rx_valid;
      logic fc;
      logic [WORD_W-1:0] rx_word;
   } mpi_main_s;

   typedef struct packed {
      mpi_tx_e st;
      logic [4:0] cnt;
      logic hi;
      logic [3:0] txd;
      logic txen;
      logic txer;
   } mpi_tx_s;

   typedef struct packed {
      logic [3:0] rxd;
      logic dv;
      logic er;
      logic in_frame;
      logic hi;
      logic [3:0] lo;
      logic err_acc;
      logic have;
      logic [8:0] held;
      logic [WORD_W-1:0] word;
      logic tog;
      logic fc_tog;
   } mpi_rx_s;

   mpi_main_s s_m;
   mpi_main_s next_m;
   mpi_tx_s s_tx;
   mpi_tx_s next_tx;
   mpi_rx_s s_rx;
   mpi_rx_s next_rx;

   logic [SY_W-1:0] sy;
   logic tx_rst_n;
   logic rx_rst_n;
   logic [WORD_W-1:0] rd_data;
   logic [3:0] rd_hi;
   logic rd_valid;
   logic pop;

   // ------------------------------------------------
   // crossings
   // ------------------------------------------------
   // levels from pins and link domains into clk_i
   mpi_sync #(.W(SY_W)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .d_i({s_rx.fc_tog, s_rx.tog, s_tx.txen, port1_carrier_sense_i,
            port1_collision_in_i, link_up_i}),
      .q_o(sy)
   );

   // reset carried into each link clock domain
   mpi_sync #(.W(1)) u_txrst (
      .clk_i(port1_transmit_clock_i),
      .rst_n_i(1'b1),
      .ce_i(1'b1),
      .d_i(rst_n_i),
      .q_o(tx_rst_n)
   );

   mpi_sync #(.W(1)) u_rxrst (
      .clk_i(port1_receive_clock_i),
      .rst_n_i(1'b1),
      .ce_i(1'b1),
      .d_i(rst_n_i),
      .q_o(rx_rst_n)
   );

   // transmit bytes from clk_i to the transmit clock
   mpi_fifo #(.W(WORD_W), .D(DEPTH)) u_txfifo (
      .wr_clk_i(clk_i),
      .wr_rst_n_i(rst_n_i),
      .wr_ce_i(ce_i),
      .wr_data_i({tx_err_i, tx_last_i, tx_data_i}),
      .wr_valid_i(tx_valid_i),
      .wr_ready_o(tx_ready_o),
      .rd_clk_i(port1_transmit_clock_i),
      .rd_rst_n_i(tx_rst_n),
      .rd_data_o(rd_data),
      .rd_valid_o(rd_valid),
      .rd_ready_i(pop)
   );

   assign rd_hi = rd_data[7:4];

   // ------------------------------------------------
   // clk_i domain: indicators, status, receive hand-off
   // ------------------------------------------------
   always_comb
   begin
      next_m = s_m;
      if (!rst_n_i)
      begin
         next_m = '0;
         next_m.link_n = 1'b1;
         next_m.act_n = 1'b1;
      end
      else if (ce_i)
      begin
         next_m.link_n = !sy[SY_LINK];
         next_m.act_n = !(sy[SY_CRS] || sy[SY_TXEN]);
         next_m.col = sy[SY_COL];
         next_m.crs = sy[SY_CRS];
         // a toggle change means a new receive word is stable
         next_m.rx_valid = sy[SY_RXTOG] != s_m.tog_seen;
         next_m.tog_seen = sy[SY_RXTOG];
         if (next_m.rx_valid)
         begin
            next_m.rx_word = s_rx.word;
         end
         next_m.fc = sy[SY_FCTOG] != s_m.fc_seen;
         next_m.fc_seen = sy[SY_FCTOG];
      end
   end

   always_ff @(posedge clk_i)
   begin
      s_m <= next_m;
   end

   // ------------------------------------------------
   // transmit domain: preamble, nibbles, gap
   // ------------------------------------------------
   always_comb
   begin
      next_tx = s_tx;
      pop = 1'b0;
      if (!tx_rst_n)
      begin
         next_tx = '{st: TX_IDLE, default: '0};
      end
      else
      begin
         unique case (s_tx.st)
            TX_IDLE:
            begin
               next_tx.txd = 4'h0;
               next_tx.txen = 1'b0;
               next_tx.txer = 1'b0;
               if (rd_valid)
               begin
                  // enable rises with the first preamble nibble
                  next_tx.st = TX_PRE;
                  next_tx.cnt = 5'h01;
                  next_tx.txen = 1'b1;
                  next_tx.txd = PREAMBLE_NIB;
               end
            end
            TX_PRE:
            begin
               if (s_tx.cnt == PREAMBLE_LEN)
               begin
                  next_tx.txd = SFD_NIB;
                  next_tx.st = TX_DATA;
                  next_tx.hi = 1'b0;
               end
               else
               begin
                  next_tx.txd = PREAMBLE_NIB;
                  next_tx.cnt = s_tx.cnt + 5'h01;
               end
            end
            TX_DATA:
            begin
               if (!s_tx.hi)
               begin
                  if (rd_valid)
                  begin
                     next_tx.txd = rd_data[3:0];
                     next_tx.txer = rd_data[WORD_ERR];
                     next_tx.hi = 1'b1;
                  end
                  else
                  begin
                     // underrun: mark the frame bad and close it
                     next_tx.txd = 4'h0;
                     next_tx.txer = 1'b1;
                     next_tx.st = TX_GAP;
                     next_tx.cnt = 5'h00;
                  end
               end
               else
               begin
                  next_tx.txd = rd_hi;
                  next_tx.txer = rd_data[WORD_ERR];
                  next_tx.hi = 1'b0;
                  pop = 1'b1;
                  if (rd_data[WORD_LAST])
                  begin
                     next_tx.st = TX_GAP;
                     next_tx.cnt = 5'h00;
                  end
               end
            end
            TX_GAP:
            begin
               next_tx.txd = 4'h0;
               next_tx.txen = 1'b0;
               next_tx.txer = 1'b0;
               next_tx.cnt = s_tx.cnt + 5'h01;
               if (s_tx.cnt == IPG_LEN - 5'h01)
               begin
                  next_tx.st = TX_IDLE;
               end
            end
            default:
            begin
               next_tx = '{st: TX_IDLE, default: '0};
            end
         endcase
      end
   end

   always_ff @(posedge port1_transmit_clock_i)
   begin
      s_tx <= next_tx;
   end

   // ------------------------------------------------
   // receive domain: capture, delimiter, byte pairing
   // ------------------------------------------------
   always_comb
   begin
      next_rx = s_rx;
      if (!rx_rst_n)
      begin
         next_rx = '0;
      end
      else
      begin
         next_rx.rxd = port1_receive_nibble_i;
         next_rx.dv = port1_receive_valid_i;
         next_rx.er = port1_receive_error_i;
         if (s_rx.dv)
         begin
            if (!s_rx.in_frame)
            begin
               if (s_rx.rxd == SFD_NIB)
               begin
                  next_rx.in_frame = 1'b1;
                  next_rx.hi = 1'b0;
                  next_rx.err_acc = 1'b0;
               end
            end
            else if (!s_rx.hi)
            begin
               next_rx.lo = s_rx.rxd;
               next_rx.hi = 1'b1;
               next_rx.err_acc = s_rx.err_acc || s_rx.er;
            end
            else
            begin
               // hand over the previous byte, hold this one
               if (s_rx.have)
               begin
                  next_rx.word[WORD_ERR] = s_rx.held[8];
                  next_rx.word[WORD_LAST] = 1'b0;
                  next_rx.word[7:0] = s_rx.held[7:0];
                  next_rx.tog = !s_rx.tog;
               end
               next_rx.held = {s_rx.err_acc || s_rx.er, s_rx.rxd, s_rx.lo};
               next_rx.have = 1'b1;
               next_rx.hi = 1'b0;
               next_rx.err_acc = 1'b0;
            end
         end
         else
         begin
            next_rx.in_frame = 1'b0;
            next_rx.hi = 1'b0;
            // frame end: last byte, an odd nibble marks it bad
            if (s_rx.have)
            begin
               next_rx.word[WORD_ERR] = s_rx.held[8] || s_rx.hi;
               next_rx.word[WORD_LAST] = 1'b1;
               next_rx.word[7:0] = s_rx.held[7:0];
               next_rx.tog = !s_rx.tog;
               next_rx.have = 1'b0;
            end
            if (s_rx.er && s_rx.rxd == FALSE_CARRIER_NIB)
            begin
               next_rx.fc_tog = !s_rx.fc_tog;
            end
         end
      end
   end

   always_ff @(posedge port1_receive_clock_i)
   begin
      s_rx <= next_rx;
   end

   // ------------------------------------------------
   // outputs
   // ------------------------------------------------
   assign port1_transmit_nibble_o = s_tx.txd;
   assign port1_transmit_enable_o = s_tx.txen;
   assign port1_transmit_error_o = s_tx.txer;
   assign port1_link_indicator_n_o = s_m.link_n;
   assign port1_activity_indicator_n_o = s_m.act_n;
   assign rx_data_o = s_m.rx_word[7:0];
   assign rx_last_o = s_m.rx_word[WORD_LAST];
   assign rx_err_o = s_m.rx_word[WORD_ERR];
   assign rx_valid_o = s_m.rx_valid;
   assign false_carrier_o = s_m.fc;
   assign collision_o = s_m.col;
   assign carrier_o = s_m.crs;

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   a_link_led: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> port1_link_indicator_n_o == !$past(sy[SY_LINK]))
      else $error("link indicator does not follow link state");

   a_act_led: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> port1_activity_indicator_n_o == !($past(sy[SY_CRS]) || $past(sy[SY_TXEN])))
      else $error("activity indicator does not follow traffic");

   a_tx_preamble: assert property (
      @(posedge port1_transmit_clock_i) disable iff (!tx_rst_n)
      $rose(port1_transmit_enable_o) |-> (port1_transmit_nibble_o == PREAMBLE_NIB)[*8]
      ##1 (port1_transmit_nibble_o == PREAMBLE_NIB)[*7] ##1 (port1_transmit_nibble_o == SFD_NIB))
      else $error("preamble or delimiter wrong");

   a_txen_end: assert property (
      @(posedge port1_transmit_clock_i) disable iff (!tx_rst_n)
      $fell(port1_transmit_enable_o) |-> $past(s_tx.st, 2) == TX_DATA)
      else $error("enable dropped outside frame data");

   a_txer_gated: assert property (
      @(posedge port1_transmit_clock_i) disable iff (!tx_rst_n)
      port1_transmit_error_o |-> port1_transmit_enable_o)
      else $error("transmit error without enable");

   a_tx_hi_nibble: assert property (
      @(posedge port1_transmit_clock_i) disable iff (!tx_rst_n)
      (s_tx.st == TX_DATA && s_tx.hi) |=> port1_transmit_nibble_o == $past(rd_hi))
      else $error("high nibble not sent second");

   a_rx_pairing: assert property (
      @(posedge port1_receive_clock_i) disable iff (!rx_rst_n)
      (s_rx.dv && s_rx.in_frame && s_rx.hi)
      |=> s_rx.held[7:0] == {$past(s_rx.rxd), $past(s_rx.lo)})
      else $error("received byte not paired low nibble first");

   a_rx_err_flag: assert property (
      @(posedge port1_receive_clock_i) disable iff (!rx_rst_n)
      (s_rx.dv && s_rx.in_frame && s_rx.er) |=> (s_rx.err_acc || s_rx.held[8]))
      else $error("receive error lost");

   a_false_carrier: assert property (
      @(posedge port1_receive_clock_i) disable iff (!rx_rst_n)
      (!s_rx.dv && s_rx.er && s_rx.rxd == FALSE_CARRIER_NIB)
      |=> s_rx.fc_tog != $past(s_rx.fc_tog))
      else $error("false carrier not signalled");

   a_rx_valid_gate: assert property (
      @(posedge port1_receive_clock_i) disable iff (!rx_rst_n)
      !s_rx.dv |=> !s_rx.in_frame)
      else $error("frame kept open without receive valid");

endmodule

/* rtl/mpi_pkg.sv */
// Purpose: shared constants and types of the second MII port
// Assumes: MII nibble framing, preamble and delimiter sent low nibble first
// Notes: field positions describe the ten bit word held in the transmit FIFO
package mpi_pkg;

   // ------------------------------------------------
   // line codes
   // ------------------------------------------------
   localparam logic [3:0] PREAMBLE_NIB = 4'h5;
   localparam logic [3:0] SFD_NIB = 4'hD;
   localparam logic [3:0] FALSE_CARRIER_NIB = 4'hE;
   localparam logic [4:0] PREAMBLE_LEN = 5'h0F;
   localparam logic [4:0] IPG_LEN = 5'h18;

   // ------------------------------------------------
   // word layout and buffer size
   // ------------------------------------------------
   localparam int FIFO_DEPTH = 8;
   localparam int WORD_W = 10;
   localparam int WORD_LAST = 8;
   localparam int WORD_ERR = 9;

   // ------------------------------------------------
   // bit positions of the synchronised levels
   // ------------------------------------------------
   localparam int SY_LINK = 0;
   localparam int SY_COL = 1;
   localparam int SY_CRS = 2;
   localparam int SY_TXEN = 3;
   localparam int SY_RXTOG = 4;
   localparam int SY_FCTOG = 5;
   localparam int SY_W = 6;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_PRE = 4'h2,
      TX_DATA = 4'h4,
      TX_GAP = 4'h8
   } mpi_tx_e;

endpackage

/* rtl/mpi_sync.sv */
// Purpose: two flip-flop synchroniser for independent levels
// Assumes: each bit may change at any time relative to clk_i
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module mpi_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mpi_sync_s;

   mpi_sync_s s;
   mpi_sync_s next_s;

   // two stage shift, frozen while ce_i is low
   always_comb
   begin
      next_s = s;
      if (!rst_n_i)
      begin
         next_s = '0;
      end
      else if (ce_i)
      begin
         next_s.s1 = d_i;
         next_s.s2 = s.s1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      s <= next_s;
   end

   assign q_o = s.s2;

endmodule

/* rtl/mpi_fifo.sv */
// Purpose: dual clock FIFO with gray coded pointers
// Assumes: depth is a power of two, at least four
// Notes: ready and valid are registered; read data is the head word
`timescale 1ns/1ps
module mpi_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   input wire logic wr_clk_i,
   input wire logic wr_rst_n_i,
   input wire logic wr_ce_i,
   input wire logic [W-1:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic rd_clk_i,
   input wire logic rd_rst_n_i,
   output logic [W-1:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i
);

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wbin;
      logic [AW:0] wgray;
      logic ready;
   } mpi_fifo_wr_s;

   typedef struct packed {
      logic [AW:0] rbin;
      logic [AW:0] rgray;
      logic valid;
   } mpi_fifo_rd_s;

   mpi_fifo_wr_s w;
   mpi_fifo_wr_s next_w;
   mpi_fifo_rd_s r;
   mpi_fifo_rd_s next_r;
   logic [AW:0] rgray_w;
   logic [AW:0] wgray_r;
   logic wen;
   logic ren;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // pointer crossings
   mpi_sync #(.W(AW + 1)) u_rsync (
      .clk_i(wr_clk_i),
      .rst_n_i(wr_rst_n_i),
      .ce_i(wr_ce_i),
      .d_i(r.rgray),
      .q_o(rgray_w)
   );

   mpi_sync #(.W(AW + 1)) u_wsync (
      .clk_i(rd_clk_i),
      .rst_n_i(rd_rst_n_i),
      .ce_i(1'b1),
      .d_i(w.wgray),
      .q_o(wgray_r)
   );

   // write side: store, advance, registered full
   always_comb
   begin
      next_w = w;
      wen = wr_valid_i && w.ready;
      if (!wr_rst_n_i)
      begin
         next_w = '0;
      end
      else if (wr_ce_i)
      begin
         if (wen)
         begin
            next_w.mem[w.wbin[AW-1:0]] = wr_data_i;
            next_w.wbin = w.wbin + 1'b1;
         end
         next_w.wgray = bin2gray(next_w.wbin);
         next_w.ready = next_w.wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
      end
   end

   always_ff @(posedge wr_clk_i)
   begin
      w <= next_w;
   end

   // read side: advance, registered empty
   always_comb
   begin
      next_r = r;
      ren = r.valid && rd_ready_i;
      if (!rd_rst_n_i)
      begin
         next_r = '0;
      end
      else
      begin
         if (ren)
         begin
            next_r.rbin = r.rbin + 1'b1;
         end
         next_r.rgray = bin2gray(next_r.rbin);
         next_r.valid = next_r.rgray != wgray_r;
      end
   end

   always_ff @(posedge rd_clk_i)
   begin
      r <= next_r;
   end

   assign wr_ready_o = w.ready;
   assign rd_valid_o = r.valid;
   assign rd_data_o = w.mem[r.rbin[AW-1:0]];

endmodule

/* bench/mpi_phy.sv */
// Purpose: behavioural MII transceiver facing the second port
// Assumes: both PHY clocks run free at the bench link rate
// Notes: rx nibble toggles while idle so stale data never looks valid
`timescale 1ns/1ps
module mpi_phy (
   output logic rx_clk_o,
   output logic [3:0] rxd_o,
   output logic rx_dv_o,
   output logic rx_er_o,
   output logic tx_clk_o,
   input wire logic [3:0] txd_i,
   input wire logic tx_en_i,
   input wire logic tx_er_i,
   output logic [8:0] tx_word_o,
   output logic tx_tog_o,
   output logic [4:0] pre_cnt_o
);
   logic drive = 0;
   logic inpkt = 0;
   logic half = 0;
   logic [3:0] lo = 4'h0;
   logic lerr = 0;
   logic [4:0] cnt = 5'h00;
   initial
   begin
      {rxd_o, rx_dv_o, rx_er_o, tx_word_o, tx_tog_o, pre_cnt_o} = '0;
      rx_clk_o = 0;
      tx_clk_o = 0;
   end
   // separate unrelated link clocks
   initial #13 forever #40 rx_clk_o = ~rx_clk_o;
   initial #27 forever #40 tx_clk_o = ~tx_clk_o;
   // idle receive nibble changes every cycle
   always @(posedge rx_clk_o)
      if (!drive) rxd_o <= ~rxd_o;
   // one receive nibble with its qualifiers
   task automatic rx_nib(input logic [3:0] n, input logic dv, input logic er);
      @(posedge rx_clk_o);
      rxd_o <= n;
      rx_dv_o <= dv;
      rx_er_o <= er;
   endtask
   task automatic rx_start();
      drive = 1;
      repeat (15) rx_nib(4'h5, 1'b1, 1'b0);
      rx_nib(4'hD, 1'b1, 1'b0);
   endtask
   // byte as two nibbles, low first
   task automatic rx_byte(input logic [7:0] b, input logic er);
      rx_nib(b[3:0], 1'b1, er);
      rx_nib(b[7:4], 1'b1, er);
   endtask
   task automatic rx_end(input logic [3:0] n, input logic er);
      drive = 1;
      rx_nib(n, 1'b0, er);
      rx_nib(~n, 1'b0, 1'b0);
      drive = 0;
   endtask
   // reassemble transmitted bytes after the delimiter
   always @(posedge tx_clk_o)
   begin
      if (!tx_en_i)
      begin
         inpkt = 0;
         cnt = 5'h00;
         half = 0;
      end
      else if (!inpkt)
      begin
         if (txd_i == 4'hD)
         begin
            inpkt = 1;
            pre_cnt_o = cnt;
         end
         else cnt = cnt + 5'h01;
      end
      else if (!half)
      begin
         lo = txd_i;
         lerr = tx_er_i;
         half = 1;
      end
      else
      begin
         tx_word_o = {lerr | tx_er_i, txd_i, lo};
         tx_tog_o = ~tx_tog_o;
         half = 0;
      end
   end
endmodule

/* bench/test_mpi_port.sv */
// Purpose: self-checking bench of the second MII port
// Assumes: ce_i held high throughout
// Notes: reset held longer than 20 cycles so PHY domains see it
`timescale 1ns/1ps
module test_mpi_port;
   import mpi_pkg::*;
   logic clk_i = 0, rst_n_i = 0, link_up_i = 0, tx_last_i = 0, tx_err_i = 0;
   logic tx_valid_i = 0, col = 0, crs = 0, full_seen = 0;
   logic [7:0] tx_data_i = 8'h00, b;
   logic tx_ready_o, rx_last_o, rx_err_o, rx_valid_o, false_carrier_o, collision_o, carrier_o;
   logic [7:0] rx_data_o;
   logic rxc, rxdv, rxer, txc, txen, txer, link_n, act_n, tog;
   logic [3:0] rxd, txd;
   logic [8:0] txw;
   logic [4:0] pre;
   logic [31:0] seed = 32'hBB6987A6;
   int error_cnt = 0, compares = 0, fc_cnt = 0, k;
   logic [9:0] exp_rx[$];
   logic [8:0] exp_tx[$];
   always #2.5 clk_i = ~clk_i;
   mpi_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link_up_i(link_up_i),
      .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_err_i(tx_err_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
      .rx_last_o(rx_last_o), .rx_err_o(rx_err_o), .rx_valid_o(rx_valid_o),
      .false_carrier_o(false_carrier_o), .collision_o(collision_o), .carrier_o(carrier_o),
      .port1_receive_clock_i(rxc), .port1_receive_nibble_i(rxd),
      .port1_receive_valid_i(rxdv), .port1_receive_error_i(rxer),
      .port1_collision_in_i(col), .port1_carrier_sense_i(crs),
      .port1_transmit_clock_i(txc), .port1_transmit_nibble_o(txd),
      .port1_transmit_enable_o(txen), .port1_transmit_error_o(txer),
      .port1_link_indicator_n_o(link_n), .port1_activity_indicator_n_o(act_n));
   mpi_phy phy_u (.rx_clk_o(rxc), .rxd_o(rxd), .rx_dv_o(rxdv), .rx_er_o(rxer),
      .tx_clk_o(txc), .txd_i(txd), .tx_en_i(txen), .tx_er_i(txer), .tx_word_o(txw),
      .tx_tog_o(tog), .pre_cnt_o(pre));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("counts: compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // offer one word, held until taken
   task automatic send_tx(input logic [7:0] d, input logic last, input logic err);
      tx_data_i <= d;
      tx_last_i <= last;
      tx_err_i <= err;
      tx_valid_i <= 1'b1;
      @(posedge clk_i);
      for (k = 0; k < 2000 && tx_ready_o !== 1'b1; k++)
      begin
         full_seen = 1;
         @(posedge clk_i);
      end
      exp_tx.push_back({err, d});
   endtask
   task automatic tx_frame(input int n, input int errat);
      for (int i = 0; i < n; i++)
      begin
         seed = lfsr(seed);
         send_tx(seed[7:0], i == n - 1, i == errat);
      end
      tx_valid_i <= 1'b0;
      for (k = 0; k < 8000 && exp_tx.size() > 0; k++) @(posedge clk_i);
      check("tx pending", exp_tx.size(), 0);
   endtask
   // monitors comparing against the oldest note
   always @(posedge clk_i)
   begin
      if (rx_valid_o === 1'b1)
         check("rx word", {rx_err_o, rx_last_o, rx_data_o}, exp_rx.pop_front());
      if (false_carrier_o === 1'b1) fc_cnt++;
   end
   always @(tog)
      if (rst_n_i) check("tx word", txw, exp_tx.pop_front());
   initial
   begin
      #300000;
      error_cnt++;
      $display("ERROR watchdog expired");
      finish_test();
   end
   // main sequence
   initial
   begin
      repeat (60) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      tx_frame(6, 2);
      check("preamble length", pre, PREAMBLE_LEN);
      $display("test tx frame done");
      repeat (40) @(posedge clk_i);
      fork
         tx_frame(16, 99);
         begin
            repeat (400) @(posedge clk_i);
            check("activity during tx", act_n, 1'b0);
         end
      join
      check("fifo refused", full_seen, 1'b1);
      $display("test tx fill done");
      phy_u.rx_start();
      for (int i = 0; i < 5; i++)
      begin
         seed = lfsr(seed);
         b = seed[7:0];
         exp_rx.push_back({i == 1, i == 4, b});
         phy_u.rx_byte(b, i == 1);
      end
      phy_u.rx_end(4'h0, 1'b0);
      for (k = 0; k < 400 && exp_rx.size() > 0; k++) @(posedge clk_i);
      check("rx pending", exp_rx.size(), 0);
      $display("test rx frame done");
      repeat (3) phy_u.rx_end(FALSE_CARRIER_NIB, 1'b1);
      phy_u.rx_end(4'h3, 1'b1);
      repeat (40) @(posedge clk_i);
      check("false carrier count", fc_cnt, 3);
      $display("test false carrier done");
      link_up_i <= 1'b1;
      crs <= 1'b1;
      col <= 1'b1;
      repeat (8) @(posedge clk_i);
      check("link led on", link_n, 1'b0);
      check("activity led on", act_n, 1'b0);
      check("carrier", carrier_o, 1'b1);
      check("collision", collision_o, 1'b1);
      link_up_i <= 1'b0;
      crs <= 1'b0;
      col <= 1'b0;
      repeat (8) @(posedge clk_i);
      check("link led off", link_n, 1'b1);
      check("activity led off", act_n, 1'b1);
      check("carrier off", carrier_o, 1'b0);
      check("collision off", collision_o, 1'b0);
      $display("test indicators done");
      finish_test();
   end
endmodule
